// ===== hw/ovfa_pkg.sv
// Constants, field layouts and state types for the output overvoltage fault action block.
// Assumes a single 125 MHz clock and a host that writes the action byte through a byte strobe.
// Functional notes
// (RULE_01) Response 00: only clamp, high side off and low side on while overvoltage.
// (RULE_02) Response 01: keep running for the delay, then act per retry field.
// (RULE_03) Response 10: disable output at once, then follow the retry field.
// (RULE_04) A write placing 11 in the response field raises a comms fault.
// (RULE_05) Every response sets the fault flag and raises alert unless masked.
// (RULE_06) Flag clears only on clear-faults, output off-then-on, or power cycling.
// (RULE_07) No-restart code keeps output off until cleared, commanded off, or power lost.
// (RULE_08) Retry 111 restarts without limit until commanded off or power lost.
// (RULE_09) Restart attempts are spaced by the separate restart interval setting.
// (RULE_10) Bits 2:0 are a delay count in 10 us units, 000 to 111.
// (RULE_11) Delay count applies only in the continue-then-act response mode.
// (RULE_12) No-restart retry code is 000; other unlisted retry codes are unsupported.
// (RULE_13) Unrecognised byte writes are ignored, keep old value, raise comms fault.
// (RULE_14) Each retry waits for interval and output decay unless decay check disabled.
package ovfa_pkg;
    localparam int          CLK_MHZ      = 125;
    localparam int          TICK_US      = 10;
    localparam int          TICK_CYC     = TICK_US * CLK_MHZ;
    localparam int          PRE_W        = 11;
    localparam int          CNT_W        = 24;
    localparam logic [7:0]  ACTION_RST   = 8'hB8;
    localparam int          RESP_MSB     = 7;
    localparam int          RESP_LSB     = 6;
    localparam int          RETRY_MSB    = 5;
    localparam int          RETRY_LSB    = 3;
    localparam int          DELAY_MSB    = 2;
    localparam int          DELAY_LSB    = 0;
    localparam logic [1:0]  RESP_CLAMP   = 2'h0;
    localparam logic [1:0]  RESP_DEGL    = 2'h1;
    localparam logic [1:0]  RESP_SHUT    = 2'h2;
    localparam logic [2:0]  RETRY_NONE   = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;

    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_DEGL  = 4'h2,
        ST_SHUT  = 4'h4,
        ST_IDLE  = 4'h8
    } ovfa_state_t;

    typedef struct packed {
        logic               armed;
        logic [PRE_W-1:0]   pre;
        logic [CNT_W-1:0]   cnt;
    } ovfa_tmr_t;

    typedef struct packed {
        ovfa_state_t        state;
        logic [7:0]         action;
        logic               fault;
        logic               runPrev;
        logic               gateEn;
        logic               clamp;
        logic               alertDrv;
        logic               comms_memory_logic_fault;
    } ovfa_core_t;

    typedef struct packed {
        logic               highSideEn;
        logic               lowSideClamp;
        logic               outputActive;
    } ovfa_gate_t;
endpackage

// ===== hw/ovfa_tick_timer.sv
// Down-counter in 10 us ticks used for the deglitch delay and the restart interval.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
module ovfa_tick_timer (
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic                   start,
    input  wire logic [ovfa_pkg::CNT_W-1:0] load,
    output logic                        expired
);
    import ovfa_pkg::*;

    ovfa_tmr_t s_ff;
    ovfa_tmr_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (start) begin
            nxt_s.armed = 1'b1;
            nxt_s.pre   = '0;
            nxt_s.cnt   = load;
        end else if (s_ff.armed && s_ff.cnt != '0) begin
            if (s_ff.pre == PRE_W'(TICK_CYC - 1)) begin // RULE_10
                nxt_s.pre = '0;
                nxt_s.cnt = s_ff.cnt - CNT_W'(1);
            end else begin
                nxt_s.pre = s_ff.pre + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // A zero load expires on the cycle after start, so delay 000 acts at once
    assign expired = s_ff.armed && (s_ff.cnt == '0);
endmodule // ovfa_tick_timer

// ===== hw/ovfa_core.sv
// Output overvoltage fault action: holds the action byte and sequences clamp, shutdown and retry.
// Assumes inputs synchronous to mclk; arst_n stands for bias power removal.
`timescale 1ns/1ps
module ovfa_core (
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    input  wire logic                       actionWrStb,
    input  wire logic [7:0]                 actionWrData,
    output logic      [7:0]                 actionRdData,
    output logic                            commsMemoryLogicFault,
    input  wire logic                       clearFaults,
    input  wire logic                       outputOnCmd,
    input  wire logic                       ovDetect,
    input  wire logic [ovfa_pkg::CNT_W-1:0] restartIntervalSetting,
    input  wire logic                       outputDecayed,
    input  wire logic                       decayCheckEn,
    input  wire logic                       alertMask,
    output logic                            statusOvFault,
    output ovfa_pkg::ovfa_gate_t            gateCtl,
    input  wire logic                       smbAlertIn,
    output logic                            smbAlertOut,
    output logic                            smbAlertOe
);
    import ovfa_pkg::*;

    ovfa_core_t         s_ff;
    ovfa_core_t         nxt_s;
    logic               tmrStart;
    logic [CNT_W-1:0]   tmrLoad;
    logic               tmrExpired;
    logic [1:0]         resp;
    logic [2:0]         retry;
    logic               runRise;
    logic               clearEv;
    logic               canRestart;

    // Only 0x00, 0x80, 0xB8, 0x40-0x47 and 0x78-0x7F are recognised
    function automatic logic isValidAction(input logic [7:0] v);
        logic [1:0] r;
        logic [2:0] t;
        r = v[RESP_MSB:RESP_LSB];
        t = v[RETRY_MSB:RETRY_LSB];
        if (r == 2'h3) begin
            isValidAction = 1'b0; // RULE_04
        end else if (t != RETRY_NONE && t != RETRY_FOREVER) begin
            isValidAction = 1'b0; // RULE_12
        end else if (r == RESP_DEGL) begin
            isValidAction = 1'b1;
        end else if (v[DELAY_MSB:DELAY_LSB] != 3'h0) begin
            isValidAction = 1'b0;
        end else if (r == RESP_CLAMP) begin
            isValidAction = (t == RETRY_NONE);
        end else begin
            isValidAction = 1'b1;
        end
    endfunction

    ovfa_tick_timer u_timer (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .start   (tmrStart),
        .load    (tmrLoad),
        .expired (tmrExpired)
    );

    assign resp       = s_ff.action[RESP_MSB:RESP_LSB];
    assign retry      = s_ff.action[RETRY_MSB:RETRY_LSB];
    assign runRise    = outputOnCmd && !s_ff.runPrev;
    assign clearEv    = clearFaults || runRise;
    // Decay check can be bypassed when the output bleeds down too slowly
    assign canRestart = tmrExpired && (outputDecayed || !decayCheckEn); // RULE_14

    always_comb begin
        nxt_s         = s_ff;
        tmrStart      = 1'b0;
        tmrLoad       = '0;
        nxt_s.comms_memory_logic_fault     = 1'b0;
        nxt_s.runPrev = outputOnCmd;

        if (actionWrStb) begin
            if (isValidAction(actionWrData)) begin
                nxt_s.action = actionWrData;
            end else begin
                nxt_s.comms_memory_logic_fault = 1'b1; // RULE_13
            end
        end

        // Set wins over clear so a fault in the clearing cycle is kept
        nxt_s.fault = ovDetect || (s_ff.fault && !clearEv); // RULE_05 RULE_06

        case (s_ff.state)
            ST_IDLE: begin
                if (outputOnCmd) begin
                    nxt_s.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!outputOnCmd) begin
                    nxt_s.state = ST_IDLE;
                end else if (ovDetect && resp == RESP_DEGL) begin
                    tmrStart    = 1'b1;
                    tmrLoad     = CNT_W'(s_ff.action[DELAY_MSB:DELAY_LSB]); // RULE_10 RULE_11
                    nxt_s.state = ST_DEGL; // RULE_02
                end else if (ovDetect && resp == RESP_SHUT) begin
                    tmrStart    = 1'b1;
                    tmrLoad     = restartIntervalSetting; // RULE_09
                    nxt_s.state = ST_SHUT; // RULE_03
                end
            end
            ST_DEGL: begin
                if (!outputOnCmd) begin
                    nxt_s.state = ST_IDLE;
                end else if (!ovDetect) begin
                    nxt_s.state = ST_RUN;
                end else if (tmrExpired) begin
                    tmrStart    = 1'b1;
                    tmrLoad     = restartIntervalSetting; // RULE_09
                    nxt_s.state = ST_SHUT; // RULE_02
                end
            end
            ST_SHUT: begin
                if (!outputOnCmd) begin
                    nxt_s.state = ST_IDLE; // RULE_07 RULE_08
                end else if (retry == RETRY_NONE) begin
                    if (clearFaults) begin
                        nxt_s.state = ST_RUN; // RULE_07
                    end
                end else if (canRestart) begin
                    nxt_s.state = ST_RUN; // RULE_08
                end
            end
            default: begin
                nxt_s.state = ST_IDLE;
            end
        endcase

        nxt_s.gateEn   = (nxt_s.state == ST_RUN) || (nxt_s.state == ST_DEGL);
        // Clamp only in response 00; other modes leave the low side to the regulator
        nxt_s.clamp    = outputOnCmd && ovDetect && (resp == RESP_CLAMP); // RULE_01
        nxt_s.alertDrv = nxt_s.fault && !alertMask; // RULE_05
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff          <= '0;
            s_ff.state    <= ST_IDLE;
            s_ff.action   <= ACTION_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign actionRdData          = s_ff.action;
    assign commsMemoryLogicFault = s_ff.comms_memory_logic_fault;
    assign statusOvFault         = s_ff.fault;
    assign gateCtl.highSideEn    = s_ff.gateEn && !s_ff.clamp; // RULE_01
    assign gateCtl.lowSideClamp  = s_ff.clamp;
    assign gateCtl.outputActive  = s_ff.gateEn;
    // Open-drain alert: only ever pulls low; the pin level is not needed here
    assign smbAlertOut           = 1'b0;
    assign smbAlertOe            = s_ff.alertDrv;
endmodule // ovfa_core

// ===== testbench/ovfa_host.sv
// Host model: writes the action byte, sends clear-faults and the output on/off command.
// Tasks are entered just after a rising edge of mclk and return just after one.
`timescale 1ns/1ps
module ovfa_host (
    input  wire logic  mclk,
    output logic       actionWrStb,
    output logic [7:0] actionWrData,
    output logic       clearFaults,
    output logic       outputOnCmd
);
    initial begin
        actionWrStb  = 1'b0;
        actionWrData = 8'h00;
        clearFaults  = 1'b0;
        outputOnCmd  = 1'b0;
    end
    // Data is scrambled after the strobe so a stale byte is never mistaken for a write
    task automatic wr(input logic [7:0] d);
        actionWrData = d;
        actionWrStb  = 1'b1;
        @(posedge mclk);
        #1 actionWrStb = 1'b0;
        actionWrData = ~d;
    endtask
    task automatic clr();
        clearFaults = 1'b1;
        @(posedge mclk);
        #1 clearFaults = 1'b0;
    endtask
    task automatic on(input logic v);
        outputOnCmd = v;
    endtask
endmodule // ovfa_host

// ===== testbench/ovfa_properties.sv
// Port-level checks for the overvoltage fault action block.
// Bound into ovfa_core; one clock domain, reset models bias power loss.
`timescale 1ns/1ps
module ovfa_properties (
    input wire logic                 mclk,
    input wire logic                 arst_n,
    input wire logic                 actionWrStb,
    input wire logic [7:0]           actionWrData,
    input wire logic [7:0]           actionRdData,
    input wire logic                 commsMemoryLogicFault,
    input wire logic                 clearFaults,
    input wire logic                 outputOnCmd,
    input wire logic                 ovDetect,
    input wire logic                 alertMask,
    input wire logic                 statusOvFault,
    input wire ovfa_pkg::ovfa_gate_t gateCtl,
    input wire logic                 smbAlertOe
);
    import ovfa_pkg::*;
    logic wrOk;
    assign wrOk = actionWrData == 8'h00 || actionWrData == 8'h80 || actionWrData == 8'hB8
                  || actionWrData[7:3] == 5'h08 || actionWrData[7:3] == 5'h0F;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_flag; ovDetect |=> statusOvFault; endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_alert; ovDetect && !alertMask ##1 !alertMask |-> smbAlertOe; endproperty
    a_alert: assert property (p_alert) else $error("alert not driven");
    property p_sticky; statusOvFault && !clearFaults && !$rose(outputOnCmd) |=> statusOvFault; endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_clamp; ovDetect && outputOnCmd && gateCtl.outputActive && actionRdData == 8'h00
        |=> gateCtl.lowSideClamp && !gateCtl.highSideEn && gateCtl.outputActive; endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");
    property p_shut; ovDetect && outputOnCmd && gateCtl.outputActive && actionRdData[7:6] == 2'h2
        |=> !gateCtl.outputActive; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_degl; $rose(ovDetect) && outputOnCmd && gateCtl.outputActive && actionRdData[7:6] == 2'h1
        && actionRdData[2:0] != 3'h0 |=> gateCtl.outputActive [*8]; endproperty
    a_degl: assert property (p_degl) else $error("deglitch cut short");
    property p_cml; actionWrStb && actionWrData[7:6] == 2'h3 |=> commsMemoryLogicFault; endproperty
    a_cml: assert property (p_cml) else $error("no comms fault");
    property p_keep; actionWrStb && !wrOk |=> $stable(actionRdData) && commsMemoryLogicFault; endproperty
    a_keep: assert property (p_keep) else $error("bad byte taken");
endmodule // ovfa_properties
bind ovfa_core ovfa_properties i_props (.mclk(mclk), .arst_n(arst_n), .actionWrStb(actionWrStb),
    .actionWrData(actionWrData), .actionRdData(actionRdData), .commsMemoryLogicFault(commsMemoryLogicFault),
    .clearFaults(clearFaults), .outputOnCmd(outputOnCmd), .ovDetect(ovDetect), .alertMask(alertMask),
    .statusOvFault(statusOvFault), .gateCtl(gateCtl), .smbAlertOe(smbAlertOe));

// ===== testbench/ovfa_core_tb.sv
// Self-checking bench for the overvoltage fault action block.
// Host model drives writes and commands; bench drives the sensed levels.
`timescale 1ns/1ps
module ovfa_core_tb;
    import ovfa_pkg::*;
    typedef struct packed {logic [7:0] d; logic [7:0] rd; logic c;} ovfa_row_t;
    logic       mclk = 1'b0;
    logic       arst_n;
    logic       ovDetect;
    logic       outputDecayed;
    logic       decayCheckEn;
    logic       alertMask;
    logic       wrStb, clrF, onCmd, comms_memory_logic_fault, flag, alertOe, alertOut;
    logic [7:0] wrData, rdData;
    logic [CNT_W-1:0] restartInt;
    ovfa_gate_t gate;
    int         fails = 0;
    int         nChecks = 0;
    int         cycles = 0;
    ovfa_row_t  rows [12] = '{'{8'h00,8'h00,1'b0}, '{8'h80,8'h80,1'b0}, '{8'hB8,8'hB8,1'b0},
        '{8'h40,8'h40,1'b0}, '{8'h47,8'h47,1'b0}, '{8'h78,8'h78,1'b0}, '{8'h7F,8'h7F,1'b0},
        '{8'hC0,8'h7F,1'b1}, '{8'h48,8'h7F,1'b1}, '{8'h88,8'h7F,1'b1}, '{8'h01,8'h7F,1'b1}, '{8'hB8,8'hB8,1'b0}};
    always #4 mclk = ~mclk;
    ovfa_host i_host (.mclk(mclk), .actionWrStb(wrStb), .actionWrData(wrData), .clearFaults(clrF),
        .outputOnCmd(onCmd));
    // Intervals of one and two ticks keep retry waits short
    ovfa_core i_dut (.mclk(mclk), .arst_n(arst_n), .actionWrStb(wrStb), .actionWrData(wrData),
        .actionRdData(rdData), .commsMemoryLogicFault(comms_memory_logic_fault), .clearFaults(clrF), .outputOnCmd(onCmd),
        .ovDetect(ovDetect), .restartIntervalSetting(restartInt), .outputDecayed(outputDecayed),
        .decayCheckEn(decayCheckEn), .alertMask(alertMask), .statusOvFault(flag), .gateCtl(gate),
        .smbAlertIn(1'b1), .smbAlertOut(alertOut), .smbAlertOe(alertOe));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic got, input logic exp);
        chk(nm, {7'h00, got}, {7'h00, exp});
    endtask
    task automatic close_out();
        if (fails == 0 && nChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        arst_n        = 1'b0;
        ovDetect      = 1'b0;
        outputDecayed = 1'b1;
        decayCheckEn  = 1'b0;
        alertMask     = 1'b0;
        restartInt    = CNT_W'(1);
        cyc(2);
        arst_n = 1'b1;
        chk("reset byte", rdData, 8'hB8);
        for (int i = 0; i < 12; i++) begin
            i_host.wr(rows[i].d);
            chk("byte", rdData, rows[i].rd);
            chk1("cml", comms_memory_logic_fault, rows[i].c);
            cyc(1);
        end
        i_host.wr(8'h00);
        i_host.on(1'b1);
        cyc(2);
        ovDetect = 1'b1;
        cyc(2);
        chk1("clamp", gate.lowSideClamp, 1'b1);
        chk1("high side", gate.highSideEn, 1'b0);
        chk1("running", gate.outputActive, 1'b1);
        chk1("alert", alertOe, 1'b1);
        chk1("alert level", alertOut, 1'b0);
        ovDetect = 1'b0;
        cyc(20);
        chk1("held", flag, 1'b1);
        i_host.clr();
        chk1("cleared", flag, 1'b0);
        alertMask = 1'b1;
        i_host.wr(8'h80);
        ovDetect = 1'b1;
        cyc(1);
        ovDetect = 1'b0;
        cyc(1);
        chk1("shut", gate.outputActive, 1'b0);
        chk1("masked", alertOe, 1'b0);
        cyc(30);
        chk1("stay off", gate.outputActive, 1'b0);
        i_host.on(1'b0);
        cyc(2);
        i_host.on(1'b1);
        cyc(2);
        chk1("off-on clear", flag, 1'b0);
        chk1("on again", gate.outputActive, 1'b1);
        alertMask = 1'b0;
        i_host.wr(8'hB8);
        // Second pass doubles the interval and bypasses the decay check
        for (int k = 0; k < 2; k++) begin
            decayCheckEn  = (k == 0);
            outputDecayed = 1'b0;
            restartInt    = CNT_W'(k + 1);
            ovDetect = 1'b1;
            cyc(1);
            ovDetect = 1'b0;
            cyc(1100 + TICK_CYC * k);
            chk1("retry wait", gate.outputActive, 1'b0);
            cyc(300);
            chk1("decay wait", gate.outputActive, outputDecayed || !decayCheckEn);
            outputDecayed = 1'b1;
            cyc(5);
            chk1("retry", gate.outputActive, 1'b1);
        end
        i_host.wr(8'h41);
        ovDetect = 1'b1;
        cyc(1000);
        chk1("deglitch", gate.outputActive, 1'b1);
        cyc(400);
        chk1("deglitch off", gate.outputActive, 1'b0);
        chk1("flag before cut", flag, 1'b1);
        ovDetect = 1'b0;
        arst_n = 1'b0;
        cyc(2);
        chk1("power cut flag", flag, 1'b0);
        chk1("power cut off", gate.outputActive, 1'b0);
        chk("power cut byte", rdData, 8'hB8);
        arst_n = 1'b1;
        cyc(2);
        chk1("power back", gate.outputActive, 1'b1);
        close_out();
    end
endmodule // ovfa_core_tb
